//--- hdl/sdwc_pkg.sv
package sdwc_pkg;

  // ==========================================================
  // filter geometry
  localparam int unsigned BIT_DIV     = 4;
  localparam int unsigned DIV_W       = 2;
  localparam int unsigned RATIO_W     = 9;
  localparam int unsigned RATIO_MIN   = 32;
  localparam int unsigned RATIO_MAX   = 256;
  localparam int unsigned CNT_W       = 16;
  localparam int unsigned ACC_W       = 17;
  localparam int unsigned OUT_W       = 16;

  // ==========================================================
  // sample qualification
  localparam int unsigned DISCARD_W   = 2;
  localparam logic [1:0]  DISCARD_CNT = 2'h2;

  // ==========================================================
  // reset values
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [ACC_W-1:0] ACC_RST = 17'h0_0000;
  localparam logic [OUT_W-1:0] OUT_RST = 16'h0000;

endpackage

//--- hdl/sdwc_sinc2_core.sv
`timescale 1ns/100ps
module sdwc_sinc2_core
  import sdwc_pkg::*;
#(
  parameter int unsigned AW = ACC_W
) (
  input  wire logic          clk_sys,     // system clock
  input  wire logic          resetn,      // async reset
  input  wire logic          soft_clear,  // sync clear
  input  wire logic          bit_tick,    // bit clock tick
  input  wire logic          bit_in,      // modulator bit
  input  wire logic          word_tick,   // word clock tick
  output logic [AW-1:0]      result,      // raw sinc2 value
  output logic               result_tick  // result updated
);

  // ==========================================================
  // double integrator at the bit rate, modulo arithmetic
  logic [AW-1:0] integ1;
  logic [AW-1:0] integ2;
  logic [AW-1:0] integ2_prev;
  logic [AW-1:0] diff1_prev;
  logic [AW-1:0] cur_diff1;
  logic [AW-1:0] cur_diff2;

  // ==========================================================
  // double differentiator at the word rate
  assign cur_diff1 = AW'(integ2 - integ2_prev);
  assign cur_diff2 = AW'(cur_diff1 - diff1_prev);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      integ1      <= ACC_RST;
      integ2      <= ACC_RST;
      integ2_prev <= ACC_RST;
      diff1_prev  <= ACC_RST;
      result      <= ACC_RST;
      result_tick <= 1'b0;
    end else if (soft_clear) begin
      integ1      <= ACC_RST;
      integ2      <= ACC_RST;
      integ2_prev <= ACC_RST;
      diff1_prev  <= ACC_RST;
      result      <= ACC_RST;
      result_tick <= 1'b0;
    end else begin
      if (bit_tick) begin
        integ1 <= AW'(integ1 + {{(AW-1){1'b0}}, bit_in});
        integ2 <= AW'(integ2 + integ1);
      end
      result_tick <= word_tick;
      if (word_tick) begin
        integ2_prev <= integ2;
        diff1_prev  <= cur_diff1;
        result      <= cur_diff2;
      end
    end
  end

endmodule

//--- hdl/sdwc_top.sv
// Operation
// - output equals an n-tap running sum of an n-tap running sum, n from 32 to 256.
// - two cascaded accumulators advance once per modulator bit.
// - two cascaded first differences run once per word clock.
// - results are unsigned, zero up to n squared minus one.
// - optional two's complement output, centred on zero.
// - bit clock is the data clock divided by four.
// - period counter makes the word clock, also driven out.
// - sample-ready raised at terminal count, with word clock falling.
// - counter period is four times the decimation ratio.
// - counter is sixteen bits, covering ratios up to 256.
// - compare threshold may change at any time while running.
// - duty cycle equals threshold over four times ratio.
// - zero threshold stops the word clock; integrators keep running.
// - first two results after threshold leaves zero are invalid.
// - first two results after input selection change are invalid.
`timescale 1ns/100ps
module sdwc_top
  import sdwc_pkg::*;
#(
  parameter int unsigned CW = CNT_W,
  parameter int unsigned AW = ACC_W,
  parameter int unsigned OW = OUT_W
) (
  input  wire logic               clk_sys,                      // system clock
  input  wire logic               resetn,                       // async reset
  input  wire logic               soft_clear,                   // sync clear
  input  wire logic               data_clk_en,                  // data clock tick
  input  wire logic               modulator_bit,                // comparator bit
  input  wire logic [RATIO_W-1:0] decimation_ratio,             // 32 to 256
  input  wire logic [CW-1:0]      word_clock_compare_threshold, // pwm compare
  input  wire logic               signed_format,                // two's complement
  input  wire logic               input_select_change,          // mux switched
  input  wire logic               sample_ack,                   // sample taken
  output logic [OW-1:0]           sample_data,                  // last result
  output logic                    sample_ready,                 // new result pulse
  output logic                    sample_pending,               // unread result
  output logic                    sample_valid,                 // result usable
  output logic                    sample_overrun,               // result lost
  output logic                    word_clock                    // pwm word clock
);

  // ==========================================================
  // ratio selection
  function automatic logic [RATIO_W-1:0] clamp_ratio(input logic [RATIO_W-1:0] r);
    if (r < RATIO_W'(RATIO_MIN)) begin
      return RATIO_W'(RATIO_MIN);
    end else if (r > RATIO_W'(RATIO_MAX)) begin
      return RATIO_W'(RATIO_MAX);
    end else begin
      return r;
    end
  endfunction

  logic [RATIO_W-1:0] ratio_sel;
  logic [CW-1:0]      period_req;

  assign ratio_sel  = clamp_ratio(decimation_ratio);
  assign period_req = CW'({ratio_sel, 2'b00});

  // ==========================================================
  // word timer
  logic          bit_tick;
  logic          word_tick;
  logic          restart;
  logic [CW-1:0] cur_period;
  logic          pwm_level;

  sdwc_word_timer #(
    .CW (CW)
  ) u_timer (
    .clk_sys     (clk_sys),
    .resetn      (resetn),
    .soft_clear  (soft_clear),
    .data_clk_en (data_clk_en),
    .period      (period_req),
    .threshold   (word_clock_compare_threshold),
    .bit_tick    (bit_tick),
    .word_tick   (word_tick),
    .restart     (restart),
    .cur_period  (cur_period),
    .pwm_out     (pwm_level)
  );

  // ==========================================================
  // sinc2 filter
  logic [AW-1:0] raw_result;
  logic          result_tick;

  sdwc_sinc2_core #(
    .AW (AW)
  ) u_core (
    .clk_sys     (clk_sys),
    .resetn      (resetn),
    .soft_clear  (soft_clear),
    .bit_tick    (bit_tick),
    .bit_in      (modulator_bit),
    .word_tick   (word_tick),
    .result      (raw_result),
    .result_tick (result_tick)
  );

  // ==========================================================
  // ratio of the word just closed
  logic [RATIO_W-1:0] word_ratio;
  logic [RATIO_W-1:0] next_word_ratio;
  logic               len_change;
  logic               next_len_change;

  assign next_word_ratio = RATIO_W'(cur_period >> 2);
  // unequal neighbouring words break the second difference
  assign next_len_change = (next_word_ratio != word_ratio);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      len_change <= 1'b0;
    end else if (soft_clear) begin
      len_change <= 1'b0;
    end else if (word_tick) begin
      len_change <= next_len_change;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      word_ratio <= RATIO_W'(RATIO_MIN);
    end else if (soft_clear) begin
      word_ratio <= RATIO_W'(RATIO_MIN);
    end else if (word_tick) begin
      word_ratio <= next_word_ratio;
    end
  end

  // ==========================================================
  // output formatting
  logic [AW-1:0] full_scale;
  logic [AW-1:0] half_scale;
  logic [AW-1:0] clamped;
  logic [AW-1:0] centred;
  logic [OW-1:0] next_data;

  // full scale is ratio squared; top code is one below it
  assign full_scale = AW'(AW'(word_ratio) * AW'(word_ratio));
  assign half_scale = AW'(full_scale >> 1);
  assign clamped    = (raw_result >= full_scale) ? AW'(full_scale - 1'b1)
                                                 : raw_result;
  assign centred    = AW'(clamped - half_scale);
  assign next_data  = signed_format ? centred[OW-1:0] : clamped[OW-1:0];

  // ==========================================================
  // result qualification
  logic [DISCARD_W-1:0] discard_cnt;
  logic [DISCARD_W-1:0] next_discard;
  logic                 invalidate;

  // restart or mux change reloads the count, even on a result cycle
  assign invalidate = restart || input_select_change;

  always_comb begin
    next_discard = discard_cnt;
    if (invalidate) begin
      next_discard = DISCARD_CNT;
    end else if (result_tick && (discard_cnt != '0)) begin
      next_discard = DISCARD_W'(discard_cnt - 1'b1);
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      discard_cnt <= DISCARD_CNT;
    end else if (soft_clear) begin
      discard_cnt <= DISCARD_CNT;
    end else begin
      discard_cnt <= next_discard;
    end
  end

  // ==========================================================
  // sample register and handshake
  logic next_pending;
  logic next_overrun;

  // a new result wins over an acknowledge in the same cycle
  assign next_pending = result_tick || (sample_pending && !sample_ack);
  assign next_overrun = (result_tick && sample_pending && !sample_ack) ||
                        (sample_overrun && !sample_ack);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sample_ready <= 1'b0;
    end else if (soft_clear) begin
      sample_ready <= 1'b0;
    end else begin
      sample_ready <= result_tick;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sample_pending <= 1'b0;
    end else if (soft_clear) begin
      sample_pending <= 1'b0;
    end else begin
      sample_pending <= next_pending;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sample_overrun <= 1'b0;
    end else if (soft_clear) begin
      sample_overrun <= 1'b0;
    end else begin
      sample_overrun <= next_overrun;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sample_data <= OUT_RST;
    end else if (soft_clear) begin
      sample_data <= OUT_RST;
    end else if (result_tick) begin
      sample_data <= next_data;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sample_valid <= 1'b0;
    end else if (soft_clear) begin
      sample_valid <= 1'b0;
    end else if (result_tick) begin
      sample_valid <= (discard_cnt == '0) && !invalidate && !len_change;
    end
  end

  // ==========================================================
  // word clock out
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      word_clock <= 1'b0;
    end else if (soft_clear) begin
      word_clock <= 1'b0;
    end else begin
      word_clock <= pwm_level;
    end
  end

endmodule

//--- hdl/sdwc_word_timer.sv
`timescale 1ns/100ps
module sdwc_word_timer
  import sdwc_pkg::*;
#(
  parameter int unsigned CW = CNT_W
) (
  input  wire logic          clk_sys,      // system clock
  input  wire logic          resetn,       // async reset
  input  wire logic          soft_clear,   // sync clear
  input  wire logic          data_clk_en,  // data clock tick
  input  wire logic [CW-1:0] period,       // requested period
  input  wire logic [CW-1:0] threshold,    // requested compare
  output logic               bit_tick,     // bit clock tick
  output logic               word_tick,    // sample boundary
  output logic               restart,      // compare left zero
  output logic [CW-1:0]      cur_period,   // period in force
  output logic               pwm_out       // word clock level
);

  // ==========================================================
  // divide-by-four bit clock
  logic [DIV_W-1:0] div_cnt;
  logic [CW-1:0]    cnt;
  logic [CW-1:0]    cur_thr;
  logic             term;
  logic [CW-1:0]    next_cnt;
  logic [CW-1:0]    next_thr;

  assign bit_tick = data_clk_en && (div_cnt == DIV_W'(BIT_DIV - 1));

  // ==========================================================
  // period counter, compare buffered at terminal count
  assign term      = data_clk_en && (cnt == CNT_RST);
  assign next_cnt  = (cnt == CNT_RST) ? CW'(period - 1'b1) : CW'(cnt - 1'b1);
  assign next_thr  = (cnt == CNT_RST) ? threshold : cur_thr;
  assign word_tick = term && (cur_thr != CNT_RST);
  assign restart   = term && (cur_thr == CNT_RST) && (threshold != CNT_RST);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      div_cnt    <= '0;
      cnt        <= CNT_RST;
      cur_thr    <= CNT_RST;
      cur_period <= CNT_RST;
      pwm_out    <= 1'b0;
    end else if (soft_clear) begin
      div_cnt    <= '0;
      cnt        <= CNT_RST;
      cur_thr    <= CNT_RST;
      cur_period <= CNT_RST;
      pwm_out    <= 1'b0;
    end else if (data_clk_en) begin
      div_cnt <= DIV_W'(div_cnt + 1'b1);
      cnt     <= next_cnt;
      cur_thr <= next_thr;
      if (term) begin
        cur_period <= period;
      end
      pwm_out <= (next_cnt < next_thr);
    end
  end

endmodule

//--- tb/sdwc_mod_model.sv
`timescale 1ns/100ps
module sdwc_mod_model (
  input  wire logic       clk_sys,      // clock
  input  wire logic       resetn,       // reset
  input  wire logic [1:0] mode,         // 0 zeros, 1 ones, 2 alternating
  output logic            data_clk_en,  // shared data clock
  output logic            modulator_bit // comparator bit
);
  logic [1:0] div;
  logic [2:0] dcnt;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      div           <= 2'h0;
      dcnt          <= 3'h0;
      data_clk_en   <= 1'b0;
      modulator_bit <= 1'b0;
    end else begin
      div         <= (div == 2'h2) ? 2'h0 : div + 2'h1;
      data_clk_en <= (div == 2'h2);
      if (data_clk_en) begin
        dcnt          <= dcnt + 3'h1;
        modulator_bit <= (mode == 2'h2) ? dcnt[2] : mode[0];
      end
    end
  end
endmodule

//--- tb/sdwc_top_sva.sv
`timescale 1ns/100ps
module sdwc_top_sva
  import sdwc_pkg::*;
#(
  parameter int unsigned OW = OUT_W
) (
  input wire logic          clk_sys,        // clock
  input wire logic          resetn,         // reset
  input wire logic          soft_clear,     // sync clear
  input wire logic          sample_ack,     // ack
  input wire logic [OW-1:0] sample_data,    // result
  input wire logic          sample_ready,   // new result
  input wire logic          sample_pending, // unread
  input wire logic          sample_valid,   // usable
  input wire logic          sample_overrun, // lost
  input wire logic          word_clock      // pwm out
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  a_ready_one_pulse: assert property (sample_ready |=> !sample_ready)
    else $error("sample_ready wider than one cycle");
  a_ready_sets_pend: assert property (sample_ready |-> sample_pending)
    else $error("pending not set by new result");
  a_ack_clears_flags: assert property (sample_ack ##1 !sample_ready |->
    !sample_pending && !sample_overrun) else $error("ack did not clear flags");
  a_clear_empties: assert property (soft_clear |=> !sample_ready && !sample_pending
    && !sample_valid && !word_clock && sample_data == '0) else $error("clear incomplete");
  a_fall_gives_ready: assert property ($fell(word_clock) && !$past(soft_clear)
    |-> sample_ready) else $error("no result with word clock fall");
  a_data_with_ready: assert property ($changed(sample_data) && !$past(soft_clear)
    |-> sample_ready) else $error("data changed without result");
  a_valid_with_ready: assert property ($changed(sample_valid) && !$past(soft_clear)
    |-> sample_ready) else $error("valid changed without result");
  a_overrun_set: assert property (sample_ready && $past(sample_pending)
    && !$past(sample_ack) |-> sample_overrun) else $error("overrun not flagged");

  c_valid_result: cover property (sample_ready && sample_valid);
  c_overrun: cover property (sample_overrun);
  c_word_fall: cover property ($fell(word_clock));
endmodule

bind sdwc_top sdwc_top_sva #(.OW(OW)) chk_u (.clk_sys(clk_sys), .resetn(resetn),
  .soft_clear(soft_clear), .sample_ack(sample_ack), .sample_data(sample_data),
  .sample_ready(sample_ready), .sample_pending(sample_pending),
  .sample_valid(sample_valid), .sample_overrun(sample_overrun), .word_clock(word_clock));

//--- tb/sdwc_top_tb.sv
`timescale 1ns/100ps
module sdwc_top_tb
  import sdwc_pkg::*;
;
  logic               clk_sys;
  logic               resetn;
  logic               soft_clear;
  logic               data_clk_en;
  logic               modulator_bit;
  logic [RATIO_W-1:0] ratio;
  logic [CNT_W-1:0]   thr;
  logic               signed_format;
  logic               sel_change;
  logic               sample_ack;
  logic [OUT_W-1:0]   sample_data;
  logic               sample_ready;
  logic               sample_pending;
  logic               sample_valid;
  logic               sample_overrun;
  logic               word_clock;
  logic [1:0]         mode;
  int                 n_mismatch;
  int                 checks_done;
  int                 cyc;
  int                 hi_cnt;
  int                 t0;
  int                 t1;
  int                 h0;
  int                 h1;

  sdwc_mod_model mdl_u (.clk_sys(clk_sys), .resetn(resetn), .mode(mode),
    .data_clk_en(data_clk_en), .modulator_bit(modulator_bit));
  sdwc_top dut_u (.clk_sys(clk_sys), .resetn(resetn), .soft_clear(soft_clear),
    .data_clk_en(data_clk_en), .modulator_bit(modulator_bit), .decimation_ratio(ratio),
    .word_clock_compare_threshold(thr), .signed_format(signed_format),
    .input_select_change(sel_change), .sample_ack(sample_ack), .sample_data(sample_data),
    .sample_ready(sample_ready), .sample_pending(sample_pending),
    .sample_valid(sample_valid), .sample_overrun(sample_overrun), .word_clock(word_clock));

  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (word_clock === 1'b1) hi_cnt <= hi_cnt + 1;
  end

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk16({15'h0000, got}, {15'h0000, exp});
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic ack_pulse();
    @(posedge clk_sys);
    sample_ack <= 1'b1;
    @(posedge clk_sys);
    sample_ack <= 1'b0;
    #1;
  endtask

  // waits for the next result and stamps its cycle and word clock high count
  task automatic get_res(input logic ack);
    int i;
    i = 0;
    do begin
      @(posedge clk_sys);
      #1;
      i++;
    end while (sample_ready !== 1'b1 && i < 4000);
    if (sample_ready !== 1'b1) begin
      n_mismatch++;
      $display("Error at %0t: no result %h %h", $time, sample_ready, 1'b1);
      end_sim();
    end else begin
      t0 = t1;
      h0 = h1;
      t1 = cyc;
      h1 = hi_cnt;
      if (ack) ack_pulse();
    end
  endtask

  task automatic t_stream(input logic [8:0] n, input logic [1:0] md, input logic sg,
                          input logic [15:0] exp);
    @(posedge clk_sys);
    ratio         <= n;
    thr           <= 16'(2 * n);
    mode          <= md;
    signed_format <= sg;
    sel_change    <= 1'b1;
    @(posedge clk_sys);
    sel_change <= 1'b0;
    get_res(1'b1);
    chk1(sample_valid, 1'b0);
    get_res(1'b1);
    chk1(sample_valid, 1'b0);
    get_res(1'b1);
    chk1(sample_valid, 1'b1);
    chk16(sample_data, exp);
    chk16(16'(t1 - t0), 16'(12 * n));
    chk16(16'(h1 - h0), 16'(6 * n));
  endtask

  task automatic t_overrun();
    get_res(1'b0);
    get_res(1'b0);
    chk1(sample_overrun, 1'b1);
    ack_pulse();
    chk1(sample_pending, 1'b0);
    chk1(sample_overrun, 1'b0);
  endtask

  task automatic t_zero();
    int rdy;
    rdy = 0;
    @(posedge clk_sys);
    thr <= 16'h0000;
    repeat (800) @(posedge clk_sys);
    h0 = hi_cnt;
    repeat (800) begin
      @(posedge clk_sys);
      #1;
      if (sample_ready === 1'b1) rdy++;
    end
    chk16(16'(rdy), 16'h0000);
    chk16(16'(hi_cnt - h0), 16'h0000);
    @(posedge clk_sys);
    thr <= 16'h0040;
    get_res(1'b1);
    chk1(sample_valid, 1'b0);
    get_res(1'b1);
    chk1(sample_valid, 1'b0);
    get_res(1'b1);
    chk1(sample_valid, 1'b1);
    chk16(sample_data, 16'h0200);
  endtask

  task automatic t_clear();
    @(posedge clk_sys);
    soft_clear <= 1'b1;
    @(posedge clk_sys);
    soft_clear <= 1'b0;
    #1;
    chk16(sample_data, 16'h0000);
    chk1(sample_valid, 1'b0);
    chk1(sample_pending, 1'b0);
  endtask

  initial begin
    {clk_sys, resetn, soft_clear, signed_format, sel_change, sample_ack} = 6'h00;
    {cyc, hi_cnt, n_mismatch, checks_done, t1, h1} = '0;
    ratio = 9'h020;
    thr   = 16'h0040;
    mode  = 2'h1;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    t_stream(9'h020, 2'h1, 1'b0, 16'h03FF);
    t_stream(9'h020, 2'h0, 1'b0, 16'h0000);
    t_stream(9'h020, 2'h1, 1'b1, 16'h01FF);
    t_stream(9'h020, 2'h0, 1'b1, 16'hFE00);
    t_stream(9'h020, 2'h2, 1'b0, 16'h0200);
    t_overrun();
    t_zero();
    t_clear();
    t_stream(9'h020, 2'h2, 1'b1, 16'h0000);
    t_stream(9'h100, 2'h1, 1'b0, 16'hFFFF);
    t_stream(9'h100, 2'h1, 1'b1, 16'h7FFF);
    end_sim();
  end
endmodule
